// ---- src/hcl_loader.sv ----
// Hub configuration loader: EEPROM image read, decode and APB view
`timescale 1ns/10ps
// Notes on behaviour
// R1: Read with two address bytes, or one byte with address bit 8 in command.
// R2: An image of all 0xFF bytes makes the hub a vendor-class device.
// R3: Loaded settings change only after a power cycle, never at run time.
// R4: Format 0xD0 takes only identifiers; everything else uses built-in defaults.
// R5: Software must write 0xD2 in byte 0 and bytes 1 to 12.
// R6: Vendor ID bytes 1-2, product ID 3-4, byte 5 ignored, device ID 6.
// R7: Byte 7 holds filter times: upper nibble live ports, lower idle; default 0x88.
// R8: Byte 8 upper nibble is the usable port mask; its ones are port count.
// R9: Usable physical ports get consecutive logical numbers from one; the map stores them from zero.
// R10: Byte 8 lower nibble flags removable logical ports.
// R11: Byte 9 is the power budget in 2 mA; defaults 0x28 FS, 0x57 HS.
// R12: Byte 10 is controller current in mA; defaults 0x50 FS, 0xAE HS.
// R13: Byte 11 is power-good delay in 2 ms; default 0x32.
// R14: Bit 7 of byte 12 lets type 0x00 pass; else such requests stall.
// R15: Bit 6 of byte 12 goes to hub characteristics bit 2.
// R16: Bit 5 of byte 12 keeps the hub at full speed only.
// R17: Bit 4 of byte 12 disables indicators and clears characteristics bit 7.
// R18: Bit 2 of byte 12 selects ganged power, shown in bits 4,3,1,0.
// R19: Image writer keeps byte 12 bits 3, 1 and 0 at zero.
// R20: Characteristics bits 1:0 read 00 for ganged, 01 for per-port switching.
// R21: Read from address 0 after reset, decode before connecting, else defaults.
module hcl_loader
   import hcl_pkg::*;
#(
   parameter logic [15:0] DEF_VID = 16'h0001, // Arbitrary value
   parameter logic [15:0] DEF_PID = 16'h0002, // Arbitrary value
   parameter logic [7:0] DEF_DID = 8'h01 // Arbitrary value
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic ee_cs_n,
   output logic ee_sck,
   output logic ee_mosi,
   input wire logic ee_miso,
   input wire logic two_byte_addr_strap,
   input wire logic hs_link,
   input wire logic desc_req,
   input wire logic [7:0] desc_type,
   output logic desc_stall,
   output hcl_pkg::hcl_cfg_t cfg,
   output logic load_done,
   output logic upstream_connect_en,
   output logic hs_allowed,
   output logic indicator_en,
   output logic [7:0] max_power_now,
   output logic [7:0] contr_current_now
);
   import hcl_pkg::*;

   localparam logic [4:0] HALF_LAST = 5'(SCK_HALF_CYC - 1);
   localparam logic [1:0] WAIT_LAST = 2'(STRAP_WAIT);
   localparam logic [3:0] IDX_LAST = 4'(IMG_BYTES - 1);

   hcl_state_t state_q;
   logic [1:0] miso_sync_q;
   logic [1:0] strap_sync_q;
   logic [4:0] div_q;
   logic [1:0] wait_q;
   logic two_byte_q;
   logic cs_n_q;
   logic launch_q;
   logic [3:0] idx_q;
   logic [7:0] img_q [IMG_BYTES];
   hcl_cfg_t cfg_q;
   logic done_q;
   logic hold_q;
   logic [31:0] prdata_q;
   logic [7:0] maxp_q;
   logic [7:0] need_q;

   wire tick = (div_q == HALF_LAST);
   wire spi_busy;
   wire spi_done;
   wire [7:0] spi_rx;
   wire [7:0] cmd_byte = two_byte_q ? EE_READ_CMD : (EE_READ_CMD | 8'(1'b0 << EE_A8_POS));
   wire [7:0] tx_byte = (state_q == ST_CMD) ? cmd_byte : EE_ADDR_START;

   hcl_spi_byte u_spi (
      .clk(clk),
      .reset_n(reset_n),
      .tick(tick),
      .start(launch_q),
      .tx_byte(tx_byte),
      .miso_s(miso_sync_q[1]),
      .busy(spi_busy),
      .done(spi_done),
      .rx_byte(spi_rx),
      .sck(ee_sck),
      .mosi(ee_mosi)
   );

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         miso_sync_q <= 2'b00;
         strap_sync_q <= 2'b00;
         div_q <= 5'h00;
      end else begin
         miso_sync_q <= {miso_sync_q[0], ee_miso};
         strap_sync_q <= {strap_sync_q[0], two_byte_addr_strap};
         div_q <= tick ? 5'h00 : div_q + 5'h01;
      end
   end

   // Load sequence; cfg_q is written in ST_DECODE only, reached once per reset
   always_ff @(posedge clk) begin
      launch_q <= 1'b0;
      if (!reset_n) begin
         state_q <= ST_IDLE;
         wait_q <= 2'h0;
         two_byte_q <= 1'b0;
         cs_n_q <= 1'b1;
         idx_q <= 4'h0;
         done_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               wait_q <= wait_q + 2'h1;
               if (wait_q == WAIT_LAST) begin
                  two_byte_q <= strap_sync_q[1]; // R1
                  cs_n_q <= 1'b0;
                  launch_q <= 1'b1;
                  state_q <= ST_CMD;
               end
            end
            ST_CMD: if (spi_done) begin
               launch_q <= 1'b1;
               state_q <= two_byte_q ? ST_AHI : ST_ALO; // R1
            end
            ST_AHI: if (spi_done) begin
               launch_q <= 1'b1;
               state_q <= ST_ALO;
            end
            ST_ALO: if (spi_done) begin
               launch_q <= 1'b1;
               state_q <= ST_DATA; // R21
            end
            ST_DATA: if (spi_done) begin
               idx_q <= idx_q + 4'h1;
               if (idx_q == IDX_LAST) begin
                  cs_n_q <= 1'b1;
                  state_q <= ST_DECODE;
               end else begin
                  launch_q <= 1'b1;
               end
            end
            ST_DECODE: begin
               done_q <= 1'b1; // R3
               state_q <= ST_DONE;
            end
            ST_DONE: state_q <= ST_DONE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (state_q == ST_DATA && spi_done) begin
         img_q[idx_q] <= spi_rx; // R21
      end
   end

   // Decode of the captured image
   function automatic logic [2:0] ones_below(input logic [3:0] m, input int unsigned n);
      logic [2:0] c;
      c = 3'h0;
      for (int k = 0; k < 4; k++) begin
         if (k < n) begin
            c = c + {2'b00, m[k]};
         end
      end
      return c;
   endfunction

   logic [IMG_BYTES-1:0] is_ff;
   genvar g;
   for (g = 0; g < IMG_BYTES; g++) begin : g_blank
      assign is_ff[g] = (img_q[g] == BLANK_BYTE);
   end

   wire blank = &is_ff;
   wire fmt_id = (img_q[B_FMT] == FMT_ID_ONLY);
   wire fmt_ext = (img_q[B_FMT] == FMT_EXT);
   wire known = (fmt_id || fmt_ext) && !blank;
   wire ext = fmt_ext && !blank;
   wire [7:0] b_filter = ext ? img_q[B_FILTER] : DEF_FILTER; // R4 R7
   wire [7:0] b_ports = ext ? img_q[B_PORTS] : DEF_PORTS; // R8
   wire [7:0] b_flags = ext ? (img_q[B_FLAGS] & FLAGS_USED) : DEF_FLAGS; // R19
   wire [3:0] mask_new = b_ports[7:4];
   wire gang_new = b_flags[F_GANG];
   wire [1:0] pwr_mode = gang_new ? PWR_GANG : PWR_INDIV; // R18 R20
   wire [7:0] lmap_new;

   for (g = 0; g < 4; g++) begin : g_lmap
      wire [2:0] below = ones_below(mask_new, g);
      assign lmap_new[2*g +: 2] = below[1:0]; // R9
   end

   hcl_cfg_t cfg_d;
   always_comb begin
      cfg_d = '0;
      cfg_d.vendor_class = blank; // R2
      cfg_d.ext_format = ext;
      cfg_d.fallback = !known && !blank; // R21
      cfg_d.vid = known ? {img_q[B_VID_H], img_q[B_VID_L]} : DEF_VID; // R6
      cfg_d.pid = known ? {img_q[B_PID_H], img_q[B_PID_L]} : DEF_PID; // R6
      cfg_d.did_hi = known ? img_q[B_DID_H] : DEF_DID; // R6
      cfg_d.live_port_fault_filter = b_filter[7:4]; // R7
      cfg_d.idle_port_fault_filter = b_filter[3:0]; // R7
      cfg_d.usable_port_mask = mask_new; // R8
      cfg_d.detachable_port_mask = b_ports[3:0]; // R10
      cfg_d.port_count = ones_below(mask_new, 4); // R8
      cfg_d.logical_port_map = lmap_new;
      cfg_d.budget_fs = ext ? img_q[B_MAXP] : DEF_MAXP_FS; // R11
      cfg_d.budget_hs = ext ? img_q[B_MAXP] : DEF_MAXP_HS; // R11
      cfg_d.need_fs = ext ? img_q[B_CTRLI] : DEF_CTRL_FS; // R12
      cfg_d.need_hs = ext ? img_q[B_CTRLI] : DEF_CTRL_HS; // R12
      cfg_d.power_good_delay = ext ? img_q[B_PWRGOOD] : DEF_PWRGOOD; // R13
      cfg_d.accept_zero_descriptor_type = b_flags[F_ACCEPT0]; // R14
      cfg_d.composite_member_flag = b_flags[F_COMPOSITE]; // R15
      cfg_d.fs_restricted = b_flags[F_FS_ONLY]; // R16
      cfg_d.indicator_suppress = b_flags[F_NO_IND]; // R17
      cfg_d.shared_power_switching = gang_new; // R18
      cfg_d.hub_characteristics = {8'h00, !b_flags[F_NO_IND], 2'b00, pwr_mode,
                                   b_flags[F_COMPOSITE], pwr_mode}; // R15 R17 R18
   end

   // Speed-dependent figures are held in flops so the ports never glitch
   wire hs_now = hs_link && !cfg_q.fs_restricted;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cfg_q <= '0;
         maxp_q <= 8'h00;
         need_q <= 8'h00;
      end else begin
         if (state_q == ST_DECODE) begin
            cfg_q <= cfg_d; // R3
         end
         maxp_q <= hs_now ? cfg_q.budget_hs : cfg_q.budget_fs; // R11
         need_q <= hs_now ? cfg_q.need_hs : cfg_q.need_fs; // R12
      end
   end

   assign cfg = cfg_q;
   assign load_done = done_q;
   assign ee_cs_n = cs_n_q;
   assign max_power_now = maxp_q;
   assign contr_current_now = need_q;
   assign upstream_connect_en = done_q && !hold_q; // R21
   assign hs_allowed = done_q && !cfg_q.fs_restricted; // R16
   assign indicator_en = done_q && !cfg_q.indicator_suppress; // R17
   wire type_ok = (desc_type == DESC_HUB) ||
                  (desc_type == DESC_ZERO && cfg_q.accept_zero_descriptor_type);
   assign desc_stall = desc_req && !type_ok; // R14

   // APB slave: zero wait states, read data fetched during setup
   wire sel_ctrl = (paddr == REG_CTRL);
   wire sel_status = (paddr == REG_STATUS);
   wire sel_ids = (paddr == REG_IDS);
   wire sel_power = (paddr == REG_POWER);
   wire sel_ports = (paddr == REG_PORTS);
   wire mapped = sel_ctrl || sel_status || sel_ids || sel_power || sel_ports;
   wire wr_ctrl = psel && penable && pwrite && sel_ctrl;
   wire [31:0] rd_status = {16'h0000, img_q[B_FMT], 4'h0, cfg_q.fallback,
                            cfg_q.ext_format, cfg_q.vendor_class, done_q};
   wire [31:0] rd_power = {cfg_q.did_hi, maxp_q, need_q, cfg_q.power_good_delay};
   wire [31:0] rd_ports = {4'h0, cfg_q.hub_characteristics, 1'b0, cfg_q.port_count,
                           cfg_q.usable_port_mask, cfg_q.detachable_port_mask};
   wire [31:0] rd_mux = sel_ctrl ? {31'h0, hold_q} :
                        sel_status ? rd_status :
                        sel_ids ? {cfg_q.pid, cfg_q.vid} :
                        sel_power ? rd_power :
                        sel_ports ? rd_ports : 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         hold_q <= CTRL_RESET;
         prdata_q <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) begin
            hold_q <= pwdata[0];
         end
         if (psel && !penable) begin
            prdata_q <= rd_mux;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_blank_vendor; // R2
      (state_q == ST_DECODE && blank) |=> cfg_q.vendor_class && !cfg_q.ext_format;
   endproperty
   a_blank_vendor: assert property (p_blank_vendor) else $error("blank image not vendor class");

   property p_id_defaults; // R4
      (state_q == ST_DECODE && fmt_id && !blank) |=>
         cfg_q.power_good_delay == DEF_PWRGOOD && cfg_q.usable_port_mask == 4'hf;
   endproperty
   a_id_defaults: assert property (p_id_defaults) else $error("short format lost defaults");

   property p_port_count; // R8
      load_done |-> cfg_q.port_count == 3'($countones(cfg_q.usable_port_mask));
   endproperty
   a_port_count: assert property (p_port_count) else $error("port count mismatch");

   property p_power_mode; // R20
      load_done |-> cfg_q.hub_characteristics[1:0] ==
         (cfg_q.shared_power_switching ? PWR_GANG : PWR_INDIV);
   endproperty
   a_power_mode: assert property (p_power_mode) else $error("power mode bits wrong");

   property p_compound; // R15
      load_done |-> cfg_q.hub_characteristics[HC_COMPOUND] == cfg_q.composite_member_flag;
   endproperty
   a_compound: assert property (p_compound) else $error("compound bit wrong");

   property p_indicator; // R17
      load_done |-> cfg_q.hub_characteristics[HC_IND] == !cfg_q.indicator_suppress
         && indicator_en == !cfg_q.indicator_suppress;
   endproperty
   a_indicator: assert property (p_indicator) else $error("indicator report wrong");

   property p_frozen; // R3
      load_done |=> load_done && $stable(cfg_q) && ee_cs_n;
   endproperty
   a_frozen: assert property (p_frozen) else $error("settings changed after load");

   property p_no_early_connect; // R21
      !load_done |-> !upstream_connect_en && !hs_allowed;
   endproperty
   a_no_early_connect: assert property (p_no_early_connect) else $error("connected early");

   property p_stall; // R14
      (desc_req && desc_type == DESC_ZERO) |-> desc_stall == !cfg_q.accept_zero_descriptor_type;
   endproperty
   a_stall: assert property (p_stall) else $error("zero type stall wrong");

   property p_addr_bytes; // R1
      (state_q == ST_CMD && spi_done) |=> (state_q == ST_AHI) == two_byte_q;
   endproperty
   a_addr_bytes: assert property (p_addr_bytes) else $error("address byte count wrong");
endmodule

// ---- shared/hcl_pkg.sv ----
// Shared constants and types for the hub configuration loader
package hcl_pkg;

   localparam int unsigned SYS_CLK_HZ = 20_000_000;
   localparam int unsigned SCK_HZ = 1_000_000;
   // Half period of the serial clock, rounded up so the rate never exceeds SCK_HZ
   localparam int unsigned SCK_HALF_CYC = (SYS_CLK_HZ + 2 * SCK_HZ - 1) / (2 * SCK_HZ);
   localparam int unsigned STRAP_WAIT = 3;

   localparam logic [7:0] EE_READ_CMD = 8'h03;
   localparam int unsigned EE_A8_POS = 3;
   localparam logic [7:0] EE_ADDR_START = 8'h00;

   localparam logic [7:0] FMT_ID_ONLY = 8'hd0;
   localparam logic [7:0] FMT_EXT = 8'hd2;
   localparam logic [7:0] BLANK_BYTE = 8'hff;
   localparam int unsigned IMG_BYTES = 13;

   localparam int unsigned B_FMT = 0;
   localparam int unsigned B_VID_L = 1;
   localparam int unsigned B_VID_H = 2;
   localparam int unsigned B_PID_L = 3;
   localparam int unsigned B_PID_H = 4;
   localparam int unsigned B_DID_H = 6;
   localparam int unsigned B_FILTER = 7;
   localparam int unsigned B_PORTS = 8;
   localparam int unsigned B_MAXP = 9;
   localparam int unsigned B_CTRLI = 10;
   localparam int unsigned B_PWRGOOD = 11;
   localparam int unsigned B_FLAGS = 12;

   localparam int unsigned F_ACCEPT0 = 7;
   localparam int unsigned F_COMPOSITE = 6;
   localparam int unsigned F_FS_ONLY = 5;
   localparam int unsigned F_NO_IND = 4;
   localparam int unsigned F_GANG = 2;
   localparam logic [7:0] FLAGS_USED = 8'hf4;

   localparam logic [7:0] DEF_FILTER = 8'h88;
   localparam logic [7:0] DEF_PORTS = 8'hff;
   localparam logic [7:0] DEF_MAXP_FS = 8'h28;
   localparam logic [7:0] DEF_MAXP_HS = 8'h57;
   localparam logic [7:0] DEF_CTRL_FS = 8'h50;
   localparam logic [7:0] DEF_CTRL_HS = 8'hae;
   localparam logic [7:0] DEF_PWRGOOD = 8'h32;
   localparam logic [7:0] DEF_FLAGS = 8'h80;

   localparam int unsigned HC_COMPOUND = 2;
   localparam int unsigned HC_IND = 7;
   localparam logic [1:0] PWR_GANG = 2'b00;
   localparam logic [1:0] PWR_INDIV = 2'b01;
   localparam logic [7:0] DESC_HUB = 8'h29;
   localparam logic [7:0] DESC_ZERO = 8'h00;

   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_IDS = 12'h008;
   localparam logic [11:0] REG_POWER = 12'h00c;
   localparam logic [11:0] REG_PORTS = 12'h010;
   localparam logic CTRL_RESET = 1'b0;

   typedef struct packed {
      logic vendor_class;
      logic ext_format;
      logic fallback;
      logic [15:0] vid;
      logic [15:0] pid;
      logic [7:0] did_hi;
      logic [3:0] live_port_fault_filter;
      logic [3:0] idle_port_fault_filter;
      logic [3:0] usable_port_mask;
      logic [3:0] detachable_port_mask;
      logic [2:0] port_count;
      logic [7:0] logical_port_map;
      logic [7:0] budget_fs;
      logic [7:0] budget_hs;
      logic [7:0] need_fs;
      logic [7:0] need_hs;
      logic [7:0] power_good_delay;
      logic accept_zero_descriptor_type;
      logic composite_member_flag;
      logic fs_restricted;
      logic indicator_suppress;
      logic shared_power_switching;
      logic [15:0] hub_characteristics;
   } hcl_cfg_t;

   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_CMD = 7'b0000010,
      ST_AHI = 7'b0000100,
      ST_ALO = 7'b0001000,
      ST_DATA = 7'b0010000,
      ST_DECODE = 7'b0100000,
      ST_DONE = 7'b1000000
   } hcl_state_t;

endpackage

// ---- src/hcl_spi_byte.sv ----
// Serial EEPROM byte shifter, mode 0, paced by a half-period tick
`timescale 1ns/10ps
module hcl_spi_byte (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic tick,
   input wire logic start,
   input wire logic [7:0] tx_byte,
   input wire logic miso_s,
   output logic busy,
   output logic done,
   output logic [7:0] rx_byte,
   output logic sck,
   output logic mosi
);
   logic busy_q;
   logic done_q;
   logic sck_q;
   logic [2:0] cnt_q;
   logic [7:0] sh_q;
   logic [7:0] rx_q;

   assign busy = busy_q;
   assign done = done_q;
   assign rx_byte = rx_q;
   assign sck = sck_q;
   assign mosi = sh_q[7];

   always_ff @(posedge clk) begin
      done_q <= 1'b0;
      if (!reset_n) begin
         busy_q <= 1'b0;
         sck_q <= 1'b0;
         cnt_q <= 3'h0;
         sh_q <= 8'h00;
         rx_q <= 8'h00;
      end else if (start && !busy_q) begin
         busy_q <= 1'b1;
         sh_q <= tx_byte;
         cnt_q <= 3'h0;
      end else if (busy_q && tick && !sck_q) begin
         // Sample on the rising edge; the device drives on the falling one
         sck_q <= 1'b1;
         rx_q <= {rx_q[6:0], miso_s};
      end else if (busy_q && tick) begin
         sck_q <= 1'b0;
         sh_q <= {sh_q[6:0], 1'b0};
         cnt_q <= cnt_q + 3'h1;
         if (cnt_q == 3'h7) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
         end
      end
   end
endmodule

// ---- verification/hcl_ee_model.sv ----
// Behavioural serial configuration memory answering mode-0 reads
`timescale 1ns/10ps
module hcl_ee_model (
   input wire logic ee_cs_n,
   input wire logic ee_sck,
   input wire logic ee_mosi,
   input wire logic two_byte,
   input wire logic [0:12][7:0] img,
   output logic ee_miso,
   output logic [23:0] hdr,
   output int frames
);
   int cnt = 0;
   int hb;
   int k;
   assign hb = two_byte ? 24 : 16;
   assign k = cnt - hb;
   initial begin
      ee_miso = 1'b0;
      hdr = '0;
      frames = 0;
   end
   always @(negedge ee_cs_n) begin
      cnt = 0;
      hdr = '0;
      frames = frames + 1;
   end
   // Command and address shift in on rising clock, MSB first
   always @(posedge ee_sck) begin
      if (!ee_cs_n) begin
         if (cnt < hb) hdr = {hdr[22:0], ee_mosi};
         cnt = cnt + 1;
      end
   end
   // Sequential read from address 0; beyond the image reads blank
   always @(negedge ee_sck) begin
      if (!ee_cs_n && cnt >= hb) ee_miso = (k / 8 < 13) ? img[k / 8][7 - k % 8] : 1'b1;
   end
   // No pull on the line, so a released line must not keep its last bit
   always @(posedge ee_cs_n) ee_miso = ~ee_miso;
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the hub configuration loader
`timescale 1ns/10ps
module testbench;
   import hcl_pkg::*;
   localparam logic [15:0] TB_VID = 16'h0a0b; // Arbitrary value
   localparam logic [15:0] TB_PID = 16'h0c0d; // Arbitrary value
   localparam logic [7:0] TB_DID = 8'h0e; // Arbitrary value
   typedef struct packed {
      logic [0:12][7:0] img;
      logic strap;
      logic [2:0] cnt;
      logic [15:0] hc;
      logic [2:0] st;
   } hcl_row_t;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic two_byte_addr_strap = 1'b1;
   logic hs_link = 1'b0;
   logic desc_req = 1'b0;
   logic [7:0] desc_type = 8'h00;
   logic [31:0] prdata, rd;
   logic pready, pslverr, ee_cs_n, ee_sck, ee_mosi, ee_miso, desc_stall, er;
   logic load_done, upstream_connect_en, hs_allowed, indicator_en;
   logic [7:0] max_power_now, contr_current_now;
   hcl_cfg_t cfg, e, keep;
   logic [0:12][7:0] img = {13{8'hff}};
   logic [23:0] hdr;
   int frames;
   int err_total = 0;
   int check_count = 0;
   int cyc_count = 0;
   logic [7:0] tcodes [3] = '{8'h29, 8'h00, 8'h05};
   // Image, strap, port count, characteristics, status {fallback, ext, vendor}
   hcl_row_t rows [6] = '{
      '{{13{8'hff}}, 1'b1, 3'd4, 16'h0089, 3'b001},
      '{{8'hd0, 8'h34, 8'h12, 8'h78, 8'h56, 8'h00, 8'h9a, 8'h11, 8'h00, 8'h22, 8'h33,
         8'h44, 8'hf4}, 1'b0, 3'd4, 16'h0089, 3'b000},
      '{{8'hd2, 8'hcd, 8'hab, 8'h01, 8'hef, 8'h5a, 8'h77, 8'h3c, 8'hd5, 8'h64, 8'hc8,
         8'h19, 8'h64}, 1'b1, 3'd3, 16'h0084, 3'b010},
      '{{8'hd2, 8'h01, 8'h02, 8'h03, 8'h04, 8'h00, 8'h05, 8'hf0, 8'h93, 8'hfa, 8'h00,
         8'hff, 8'h90}, 1'b0, 3'd2, 16'h0009, 3'b010},
      '{{8'hd4, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88, 8'h99, 8'haa,
         8'hbb, 8'hc0}, 1'b1, 3'd4, 16'h0089, 3'b100},
      '{{8'hd2, 8'haa, 8'h55, 8'h55, 8'haa, 8'h00, 8'hff, 8'h00, 8'h80, 8'h01, 8'hff,
         8'h00, 8'h00}, 1'b0, 3'd1, 16'h0089, 3'b010}};

   always #25 clk = ~clk;

   hcl_loader #(.DEF_VID(TB_VID), .DEF_PID(TB_PID), .DEF_DID(TB_DID)) u_dut (.clk(clk),
      .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ee_cs_n(ee_cs_n),
      .ee_sck(ee_sck), .ee_mosi(ee_mosi), .ee_miso(ee_miso),
      .two_byte_addr_strap(two_byte_addr_strap), .hs_link(hs_link), .desc_req(desc_req),
      .desc_type(desc_type), .desc_stall(desc_stall), .cfg(cfg), .load_done(load_done),
      .upstream_connect_en(upstream_connect_en), .hs_allowed(hs_allowed),
      .indicator_en(indicator_en), .max_power_now(max_power_now),
      .contr_current_now(contr_current_now));

   hcl_ee_model u_ee (.ee_cs_n(ee_cs_n), .ee_sck(ee_sck), .ee_mosi(ee_mosi),
      .two_byte(two_byte_addr_strap), .img(img), .ee_miso(ee_miso), .hdr(hdr), .frames(frames));

   task automatic end_of_test();
      if (err_total == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [191:0] got, input logic [191:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] r, output logic x);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      r = prdata;
      x = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Power cycle: the image is swapped only while reset is held
   task automatic load(input logic [0:12][7:0] m, input logic s);
      int n = 0;
      @(posedge clk);
      reset_n <= 1'b0;
      img <= m;
      two_byte_addr_strap <= s;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      #1 chk({load_done, upstream_connect_en, ee_cs_n}, 3'b001);
      while (load_done !== 1'b1 && n < 5000) begin
         @(posedge clk);
         n++;
      end
      #1 chk(load_done, 1'b1);
   endtask

   function automatic hcl_cfg_t expect_cfg(input logic [0:12][7:0] m);
      hcl_cfg_t x;
      logic [0:12][7:0] d;
      logic [2:0] n;
      logic ids, ext;
      x = '0;
      n = 3'd0;
      ext = (m[0] == FMT_EXT);
      ids = ext || m[0] == FMT_ID_ONLY;
      d = {8'h00, TB_VID[7:0], TB_VID[15:8], TB_PID[7:0], TB_PID[15:8], 8'h00, TB_DID,
         DEF_FILTER, DEF_PORTS, DEF_MAXP_FS, DEF_CTRL_FS, DEF_PWRGOOD, DEF_FLAGS};
      for (int i = 1; i < 13; i++) if ((i < 7 && ids) || ext) d[i] = m[i];
      x.vendor_class = (m == {13{8'hff}});
      x.ext_format = ext;
      x.fallback = !ids;
      x.vid = {d[2], d[1]};
      x.pid = {d[4], d[3]};
      x.did_hi = d[6];
      {x.live_port_fault_filter, x.idle_port_fault_filter} = d[7];
      {x.usable_port_mask, x.detachable_port_mask} = d[8];
      for (int i = 0; i < 4; i++) if (x.usable_port_mask[i]) begin
         x.logical_port_map[2*i+:2] = n[1:0];
         n++;
      end
      x.port_count = n;
      x.budget_fs = d[9];
      x.budget_hs = ext ? d[9] : DEF_MAXP_HS;
      x.need_fs = d[10];
      x.need_hs = ext ? d[10] : DEF_CTRL_HS;
      x.power_good_delay = d[11];
      {x.accept_zero_descriptor_type, x.composite_member_flag} = d[12][7:6];
      {x.fs_restricted, x.indicator_suppress} = d[12][5:4];
      x.shared_power_switching = d[12][2];
      x.hub_characteristics = {8'h00, !d[12][4], 3'b000, !d[12][2], d[12][6], 1'b0,
         !d[12][2]};
      return x;
   endfunction

   always @(posedge clk) begin
      cyc_count <= cyc_count + 1;
      if (cyc_count == 60000) begin
         err_total++;
         end_of_test();
      end
   end

   initial begin
      for (int r = 0; r < 6; r++) begin
         load(rows[r].img, rows[r].strap);
         e = expect_cfg(rows[r].img);
         keep = cfg;
         // Fallback flag of a blank image and unused map slots are left open
         if (e.vendor_class) keep.fallback = e.fallback;
         for (int i = 0; i < 4; i++) if (!e.usable_port_mask[i]) keep.logical_port_map[2*i+:2] = 0;
         chk(keep, e);
         chk({cfg.port_count, cfg.hub_characteristics}, {rows[r].cnt, rows[r].hc});
         chk(hdr, rows[r].strap ? {EE_READ_CMD, 16'h0000} : {8'h00, EE_READ_CMD, 8'h00});
         chk({ee_cs_n, frames}, {1'b1, r + 1});
         chk({hs_allowed, indicator_en}, {!e.fs_restricted, !e.indicator_suppress});
         chk({max_power_now, contr_current_now}, {e.budget_fs, e.need_fs});
         @(posedge clk);
         hs_link <= 1'b1;
         repeat (2) @(posedge clk);
         #1 chk({max_power_now, contr_current_now}, e.fs_restricted ? {e.budget_fs, e.need_fs}
            : {e.budget_hs, e.need_hs});
         @(posedge clk);
         hs_link <= 1'b0;
         foreach (tcodes[k]) begin
            @(posedge clk);
            desc_req <= 1'b1;
            desc_type <= tcodes[k];
            @(posedge clk);
            #1 chk(desc_stall, !(tcodes[k] == DESC_HUB
               || (tcodes[k] == DESC_ZERO && e.accept_zero_descriptor_type)));
         end
         @(posedge clk);
         desc_req <= 1'b0;
         apb(1'b0, REG_STATUS, 32'h0, rd, er);
         chk({rd[15:8], rd[0], er}, {rows[r].img[0], 1'b1, 1'b0});
         chk(e.vendor_class ? rd[2:1] : rd[3:1], e.vendor_class ? rows[r].st[1:0] : rows[r].st);
         apb(1'b0, REG_IDS, 32'h0, rd, er);
         chk(rd, {e.pid, e.vid});
         apb(1'b0, REG_POWER, 32'h0, rd, er);
         chk(rd, {e.did_hi, e.budget_fs, e.need_fs, e.power_good_delay});
         apb(1'b0, REG_PORTS, 32'h0, rd, er);
         chk(rd, {4'h0, e.hub_characteristics, 1'b0, e.port_count, e.usable_port_mask,
            e.detachable_port_mask});
      end
      // New image without a power cycle must change nothing
      keep = cfg;
      @(posedge clk);
      img <= {13{8'hff}};
      repeat (3000) @(posedge clk);
      #1 chk({cfg, ee_cs_n, frames}, {keep, 1'b1, 32'd6});
      apb(1'b1, REG_CTRL, 32'h1, rd, er);
      #1 chk({upstream_connect_en, er}, 2'b00);
      apb(1'b1, REG_STATUS, 32'hffff_ffff, rd, er);
      apb(1'b0, REG_STATUS, 32'h0, rd, er);
      chk(rd[15:0], 16'hd205);
      apb(1'b0, 12'h020, 32'h0, rd, er);
      chk({rd, er}, {32'h0, 1'b1});
      apb(1'b1, 12'h020, 32'h0, rd, er);
      apb(1'b0, REG_CTRL, 32'h0, rd, er);
      chk({rd[0], er}, 2'b10);
      apb(1'b1, REG_CTRL, 32'h0, rd, er);
      #1 chk(upstream_connect_en, 1'b1);
      load({13{8'hff}}, 1'b0);
      chk({cfg.vendor_class, hdr, frames}, {1'b1, 8'h00, EE_READ_CMD, 8'h00, 32'd7});
      end_of_test();
   end
endmodule
